/* File: logic/sdc_top.sv */
// Step/direction input logic with its APB-reachable configuration.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Subdivision select offers fifteen resolutions from full step to 256x.
// - After the last step, wait 0 to 6350 ms in 50 ms units, then hold.
// - Run current setting, 0.5 to 5.0 A peak in 0.05 A units.
// - Hold current setting, 0.0 to 5.0 A in 0.05 A units.
// - Steps counted on rising or falling edge as configured.
// - Direction sense defaults to counter-clockwise; alternative setting reverses it.
// - Direction input high gives counter-clockwise, low clockwise, by default.
// - Disable active low by default; polarity setting makes high disable.
// - While disabled, all winding current is removed.
// - Smoothness selector 0 to 3 picks the current waveform shape.
// - Each accepted step advances position by exactly one subdivision_select.
module sdc_top #(
  parameter int DELAY_UNIT_CYCLES = sdc_pkg::DELAY_UNIT_CYC,
  parameter int POS_W = 32
) (
  input wire logic clk_i, // 20 MHz clock
  input wire logic reset_i, // Synchronous active-high reset
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire logic step_i, // Step pulse pin
  input wire logic dir_i, // Direction pin
  input wire logic disable_i, // Disable pin, polarity configurable
  output logic step_o, // One-cycle subdivision_select advance pulse
  output logic dir_cw_o, // High when rotation is clockwise
  output logic [sdc_pkg::STEP_W-1:0] subdivision_select_o, // Microsteps per full step
  output logic [sdc_pkg::CUR_W-1:0] current_o, // Current command, 0.05 A units
  output logic [1:0] smooth_o, // Waveform shape
  output logic disabled_o, // Drive current removed
  output logic [POS_W-1:0] position_o // Signed subdivision_select position
);

  // =====================================================================
  // Input synchronisers
  // =====================================================================
  sdc_pkg::sdc_pins_s stable_reg;
  logic step_lvl;
  logic dir_lvl;
  logic dis_lvl;

  // Direction and disable rest high like an open opto input, so leaving reset
  // never reads as a disable command or a direction change.
  sdc_sync3 #(.RESET_LEVEL(1'b0)) step_sync_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(step_i),
    .level_o(step_lvl)
  );

  sdc_sync3 #(.RESET_LEVEL(1'b1)) dir_sync_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(dir_i),
    .level_o(dir_lvl)
  );

  sdc_sync3 #(.RESET_LEVEL(1'b1)) dis_sync_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(disable_i),
    .level_o(dis_lvl)
  );

  assign stable_reg = '{step: step_lvl, dir: dir_lvl, dis: dis_lvl};

  // =====================================================================
  // Configuration registers over APB
  // =====================================================================
  sdc_pkg::sdc_cfg_s cfg_reg;
  sdc_pkg::sdc_cfg_s cfg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic access;
  logic wr_en;
  logic mapped;
  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] pos_next;
  sdc_pkg::sdc_cur_e cur_reg;
  sdc_pkg::sdc_cur_e cur_next;
  logic [sdc_pkg::SUBDIV_W-1:0] wr_subdiv;
  logic [sdc_pkg::DELAY_W-1:0] wr_delay;
  logic [sdc_pkg::CUR_W-1:0] wr_cur;

  // Zero-wait slave. The setup cycle loads the read word into a flip-flop, and a
  // write lands only at the access edge, where the master samples pready, so a
  // setup cycle alone never changes a setting.
  assign access = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign wr_subdiv = pwdata_i[sdc_pkg::SUBDIV_W-1:0];
  assign wr_delay = pwdata_i[sdc_pkg::DELAY_W-1:0];
  assign wr_cur = pwdata_i[sdc_pkg::CUR_W-1:0];

  // Read side, decoded once per transfer in the setup cycle.
  always_comb begin
    mapped = 1'b1;
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (access) begin
      rdata_next = '0;
      unique case (paddr_i)
        sdc_pkg::ADDR_SUBDIV: begin
          rdata_next[sdc_pkg::SUBDIV_W-1:0] = cfg_reg.subdiv;
        end
        sdc_pkg::ADDR_HOLD_DELAY: begin
          rdata_next[sdc_pkg::DELAY_W-1:0] = cfg_reg.delay;
        end
        sdc_pkg::ADDR_RUN_CURRENT: begin
          rdata_next[sdc_pkg::CUR_W-1:0] = cfg_reg.run_cur;
        end
        sdc_pkg::ADDR_HOLD_CURRENT: begin
          rdata_next[sdc_pkg::CUR_W-1:0] = cfg_reg.hold_cur;
        end
        sdc_pkg::ADDR_CONTROL: begin
          rdata_next[sdc_pkg::CTRL_EDGE_BIT] = cfg_reg.step_falling;
          rdata_next[sdc_pkg::CTRL_DIR_BIT] = cfg_reg.dir_cw;
          rdata_next[sdc_pkg::CTRL_DIS_BIT] = cfg_reg.dis_high;
          rdata_next[sdc_pkg::CTRL_SMOOTH_LSB +: sdc_pkg::CTRL_SMOOTH_W] = cfg_reg.smooth;
        end
        sdc_pkg::ADDR_STATUS: begin
          rdata_next[sdc_pkg::STAT_DIS_BIT] = disabled_o;
          rdata_next[sdc_pkg::STAT_CW_BIT] = dir_cw_o;
          rdata_next[sdc_pkg::STAT_STATE_LSB +: sdc_pkg::STAT_STATE_W] = cur_reg;
          rdata_next[sdc_pkg::STAT_STEP_BIT] = stable_reg.step;
        end
        sdc_pkg::ADDR_POSITION: begin
          rdata_next[POS_W-1:0] = pos_reg;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
      err_next = !mapped;
    end
  end

  // Write side. Out-of-range values are dropped so every setting stays legal.
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_en) begin
      unique case (paddr_i)
        sdc_pkg::ADDR_SUBDIV: begin
          if (wr_subdiv <= sdc_pkg::SUBDIV_MAX) begin
            cfg_next.subdiv = wr_subdiv;
          end
        end
        sdc_pkg::ADDR_HOLD_DELAY: begin
          cfg_next.delay = wr_delay;
        end
        sdc_pkg::ADDR_RUN_CURRENT: begin
          if (wr_cur >= sdc_pkg::RUN_MIN && wr_cur <= sdc_pkg::CUR_MAX) begin
            cfg_next.run_cur = wr_cur;
          end
        end
        sdc_pkg::ADDR_HOLD_CURRENT: begin
          if (wr_cur <= sdc_pkg::CUR_MAX) begin
            cfg_next.hold_cur = wr_cur;
          end
        end
        sdc_pkg::ADDR_CONTROL: begin
          cfg_next.step_falling = pwdata_i[sdc_pkg::CTRL_EDGE_BIT];
          cfg_next.dir_cw = pwdata_i[sdc_pkg::CTRL_DIR_BIT];
          cfg_next.dis_high = pwdata_i[sdc_pkg::CTRL_DIS_BIT];
          cfg_next.smooth =
            pwdata_i[sdc_pkg::CTRL_SMOOTH_LSB +: sdc_pkg::CTRL_SMOOTH_W];
        end
        default: begin
          cfg_next = cfg_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_reg <= '{subdiv: sdc_pkg::SUBDIV_RESET, delay: sdc_pkg::DELAY_RESET,
                   run_cur: sdc_pkg::RUN_RESET, hold_cur: sdc_pkg::HOLD_RESET,
                   step_falling: 1'b0, dir_cw: 1'b0, dis_high: 1'b0,
                   smooth: sdc_pkg::SMOOTH_RESET};
      rdata_reg <= '0;
      err_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign pready_o = 1'b1;
  assign prdata_o = rdata_reg;
  assign pslverr_o = err_reg && psel_i && penable_i;

  // =====================================================================
  // Step detection, direction and position
  // =====================================================================
  logic prev_step_reg;
  logic step_event;
  logic dis_active;
  logic step_pulse_reg;
  logic cw_reg;

  assign dis_active = cfg_reg.dis_high ? stable_reg.dis : !stable_reg.dis;
  assign step_event = (cfg_reg.step_falling ? (prev_step_reg && !stable_reg.step)
                       : (!prev_step_reg && stable_reg.step)) && !dis_active;

  // A high pin means counter-clockwise unless the sense is swapped.
  always_comb begin
    pos_next = pos_reg;
    if (step_event) begin
      pos_next = (stable_reg.dir ^ cfg_reg.dir_cw) ? pos_reg + 1'b1 : pos_reg - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_step_reg <= 1'b0;
      step_pulse_reg <= 1'b0;
      cw_reg <= 1'b0;
      pos_reg <= '0;
    end else begin
      prev_step_reg <= stable_reg.step;
      step_pulse_reg <= step_event;
      cw_reg <= !(stable_reg.dir ^ cfg_reg.dir_cw);
      pos_reg <= pos_next;
    end
  end

  // =====================================================================
  // Run/hold current and the hold delay timer
  // =====================================================================
  logic [31:0] unit_cnt_reg;
  logic [31:0] unit_cnt_next;
  logic [sdc_pkg::DELAY_W-1:0] units_reg;
  logic [sdc_pkg::DELAY_W-1:0] units_next;
  logic [sdc_pkg::CUR_W-1:0] cur_val_reg;
  logic [sdc_pkg::CUR_W-1:0] cur_val_next;

  always_comb begin
    cur_next = cur_reg;
    unit_cnt_next = unit_cnt_reg;
    units_next = units_reg;
    unique case (cur_reg)
      sdc_pkg::SDC_OFF: begin
        if (!dis_active) begin
          cur_next = sdc_pkg::SDC_HOLD;
        end
      end
      sdc_pkg::SDC_RUN: begin
        if (step_event) begin
          unit_cnt_next = '0;
          units_next = '0;
        end else if (units_reg >= cfg_reg.delay) begin
          cur_next = sdc_pkg::SDC_HOLD;
        end else if (unit_cnt_reg == 32'(DELAY_UNIT_CYCLES - 1)) begin
          unit_cnt_next = '0;
          units_next = units_reg + 1'b1;
        end else begin
          unit_cnt_next = unit_cnt_reg + 1'b1;
        end
      end
      sdc_pkg::SDC_HOLD: begin
        if (step_event) begin
          cur_next = sdc_pkg::SDC_RUN;
          unit_cnt_next = '0;
          units_next = '0;
        end
      end
    endcase
    if (dis_active) begin
      cur_next = sdc_pkg::SDC_OFF;
    end
    unique case (cur_next)
      sdc_pkg::SDC_RUN: cur_val_next = cfg_reg.run_cur;
      sdc_pkg::SDC_HOLD: cur_val_next = cfg_reg.hold_cur;
      default: cur_val_next = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cur_reg <= sdc_pkg::SDC_OFF;
      unit_cnt_reg <= '0;
      units_reg <= '0;
      cur_val_reg <= '0;
    end else begin
      cur_reg <= cur_next;
      unit_cnt_reg <= unit_cnt_next;
      units_reg <= units_next;
      cur_val_reg <= cur_val_next;
    end
  end

  // =====================================================================
  // Outputs
  // =====================================================================
  assign step_o = step_pulse_reg;
  assign dir_cw_o = cw_reg;
  assign subdivision_select_o = sdc_pkg::SUBDIV_TABLE[cfg_reg.subdiv];
  assign current_o = cur_val_reg;
  assign smooth_o = cfg_reg.smooth;
  assign disabled_o = (cur_reg == sdc_pkg::SDC_OFF);
  assign position_o = pos_reg;

endmodule

// =====================================================================
// Pin synchroniser
// =====================================================================
// Three-stage pin synchroniser whose output follows only when stages two and three agree.
module sdc_sync3 #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clk_i, // Block clock
  input wire logic reset_i, // Synchronous active-high reset
  input wire logic pin_i, // Asynchronous pin level
  output logic level_o // Filtered level in the clock domain
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pin_i};
    level_next = level_reg;
    // A single-cycle glitch from a slow opto edge never reaches the output.
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stage_reg <= {3{RESET_LEVEL}};
      level_reg <= RESET_LEVEL;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule

`default_nettype wire

/* File: shared/sdc_pkg.sv */
// Package with the constants, enumerations and carrier types of the step/direction input block.
package sdc_pkg;

  // =====================================================================
  // Register map (byte addresses, one aligned 32-bit word each)
  // =====================================================================
  localparam logic [7:0] ADDR_SUBDIV = 8'h00;
  localparam logic [7:0] ADDR_HOLD_DELAY = 8'h04;
  localparam logic [7:0] ADDR_RUN_CURRENT = 8'h08;
  localparam logic [7:0] ADDR_HOLD_CURRENT = 8'h0c;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_POSITION = 8'h18;

  // =====================================================================
  // Field layouts of the control and status registers
  // =====================================================================
  localparam int CTRL_EDGE_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_DIS_BIT = 2;
  localparam int CTRL_SMOOTH_LSB = 4;
  localparam int CTRL_SMOOTH_W = 2;
  localparam int STAT_DIS_BIT = 0;
  localparam int STAT_CW_BIT = 1;
  localparam int STAT_STATE_LSB = 2;
  localparam int STAT_STATE_W = 2;
  localparam int STAT_STEP_BIT = 4;

  // =====================================================================
  // Field widths, limits and reset values
  // =====================================================================
  localparam int SUBDIV_W = 4;
  localparam logic [3:0] SUBDIV_MAX = 4'he;
  localparam logic [3:0] SUBDIV_RESET = 4'h4;
  localparam int DELAY_W = 7;
  localparam logic [6:0] DELAY_RESET = 7'h0a;
  localparam int CUR_W = 7;
  localparam logic [6:0] RUN_MIN = 7'h0a;
  localparam logic [6:0] CUR_MAX = 7'h64;
  localparam logic [6:0] RUN_RESET = 7'h14;
  localparam logic [6:0] HOLD_RESET = 7'h0a;
  localparam logic [1:0] SMOOTH_RESET = 2'h2;
  localparam int STEP_W = 9;

  // =====================================================================
  // Timing
  // =====================================================================
  localparam int CLK_HZ = 20_000_000;
  localparam int DELAY_UNIT_MS = 50;
  localparam int DELAY_UNIT_CYC = CLK_HZ / 1000 * DELAY_UNIT_MS;

  // Subdivision_select subdivision codes, coded 0..14 in the order of the table.
  localparam logic [8:0] SUBDIV_TABLE [0:14] = '{
    9'h001, 9'h002, 9'h004, 9'h005, 9'h008, 9'h00a, 9'h010, 9'h019,
    9'h020, 9'h032, 9'h040, 9'h07d, 9'h080, 9'h0fa, 9'h100};

  typedef enum logic [1:0] {
    SDC_OFF,
    SDC_RUN,
    SDC_HOLD
  } sdc_cur_e;

  typedef struct packed {
    logic step;
    logic dir;
    logic dis;
  } sdc_pins_s;

  typedef struct packed {
    logic [SUBDIV_W-1:0] subdiv;
    logic [DELAY_W-1:0] delay;
    logic [CUR_W-1:0] run_cur;
    logic [CUR_W-1:0] hold_cur;
    logic step_falling;
    logic dir_cw;
    logic dis_high;
    logic [CTRL_SMOOTH_W-1:0] smooth;
  } sdc_cfg_s;

endpackage

/* File: testbench/sdc_pulse_gen.sv */
// Model of the external step pulse generator driving the pins of the block.
`timescale 1ns/100ps
`default_nettype none
module sdc_pulse_gen #(
  parameter int HALF = 8
) (
  input wire logic clk_i, // Pacing clock
  output logic step_o, // Step pin
  output logic dir_o, // Direction pin
  output logic dis_o // Disable pin
);
  // Open opto inputs read high, so direction and disable rest high.
  initial begin
    step_o = 1'b0;
    dir_o = 1'b1;
    dis_o = 1'b1;
  end
  task automatic level(input logic v);
    @(posedge clk_i);
    step_o <= v;
    repeat (HALF - 1) @(posedge clk_i);
  endtask
  // Direction settles seven cycles ahead because the block wants it stable before an edge.
  task automatic pulses(input int n, input logic cw);
    @(posedge clk_i);
    dir_o <= !cw;
    repeat (6) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      level(1'b1);
      level(1'b0);
    end
  endtask
  task automatic set_dis(input logic v);
    @(posedge clk_i);
    dis_o <= v;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* File: testbench/sdc_top_asserts.sv */
// Concurrent checks on the ports of the step/direction input block.
`timescale 1ns/100ps
`default_nettype none
module sdc_top_asserts #(
  parameter int POS_W = 32
) (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pslverr_o, // APB error
  input wire logic step_o, // Subdivision_select pulse
  input wire logic dir_cw_o, // Clockwise flag
  input wire logic [sdc_pkg::STEP_W-1:0] subdivision_select_o, // Microsteps
  input wire logic [sdc_pkg::CUR_W-1:0] current_o, // Current command
  input wire logic disabled_o, // Drive off
  input wire logic [POS_W-1:0] position_o // Position
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Pins must stay three cycles per level, so two advances are never this close.
  a_step_single: assert property (step_o |=> !step_o [*4])
    else $error("step pulse too long or repeated too soon");
  a_step_ccw: assert property (step_o && !dir_cw_o |-> position_o == $past(position_o) + 1'b1)
    else $error("counter-clockwise step did not add one");
  a_step_cw: assert property (step_o && dir_cw_o |-> position_o == $past(position_o) - 1'b1)
    else $error("clockwise step did not subtract one");
  a_idle_still: assert property (!step_o |-> $stable(position_o))
    else $error("position moved without a step");
  a_run_resume: assert property (step_o |-> ##[0:1] current_o >= sdc_pkg::RUN_MIN)
    else $error("step did not restore run current");
  a_off_no_cur: assert property (disabled_o && $past(disabled_o) |-> current_o == '0)
    else $error("current present while disabled");
  a_off_no_step: assert property (disabled_o && $past(disabled_o) |-> !step_o)
    else $error("step accepted while disabled");
  a_subdiv_legal: assert property (subdivision_select_o inside {9'h001, 9'h002, 9'h004,
    9'h005, 9'h008, 9'h00a, 9'h010, 9'h019, 9'h020, 9'h032, 9'h040, 9'h07d, 9'h080,
    9'h0fa, 9'h100}) else $error("subdivision outside the offered set");
  a_err_phase: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("bus error outside access phase");
endmodule
bind sdc_top sdc_top_asserts #(.POS_W(POS_W)) chk_u (.clk_i, .reset_i, .psel_i, .penable_i,
  .pslverr_o, .step_o, .dir_cw_o, .subdivision_select_o, .current_o, .disabled_o, .position_o);
`default_nettype wire

/* File: testbench/tb_step_dir_input_config.sv */
// Self-checking testbench of the step/direction input block.
`timescale 1ns/100ps
`default_nettype none
module tb_step_dir_input_config;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic e;
  } sdc_row_s;
  logic clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, e;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, q, position_o;
  logic step_pin, dir_pin, dis_pin, step_o, dir_cw_o, disabled_o;
  logic [8:0] subdivision_select_o;
  logic [6:0] current_o;
  logic [1:0] smooth_o;
  int bad_count = 0;
  int num_checks = 0;
  sdc_row_s rows [10] = '{'{8'h00, 32'h0e, 32'h0e, 1'b0}, '{8'h00, 32'h0f, 32'h0e, 1'b0},
    '{8'h04, 32'h7f, 32'h7f, 1'b0}, '{8'h08, 32'h64, 32'h64, 1'b0},
    '{8'h08, 32'h09, 32'h64, 1'b0}, '{8'h08, 32'h0a, 32'h0a, 1'b0},
    '{8'h0c, 32'h00, 32'h00, 1'b0}, '{8'h0c, 32'h65, 32'h00, 1'b0},
    '{8'h10, 32'h37, 32'h37, 1'b0}, '{8'h1c, 32'h01, 32'h00, 1'b1}};
  logic [8:0] sub_exp [15] = '{9'h001, 9'h002, 9'h004, 9'h005, 9'h008, 9'h00a, 9'h010,
    9'h019, 9'h020, 9'h032, 9'h040, 9'h07d, 9'h080, 9'h0fa, 9'h100};
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
  logic [31:0] rv [6] = '{32'h04, 32'h0a, 32'h14, 32'h0a, 32'h20, 32'h00};
  sdc_top #(.DELAY_UNIT_CYCLES(4)) uut (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .step_i(step_pin),
    .dir_i(dir_pin), .disable_i(dis_pin), .step_o, .dir_cw_o, .subdivision_select_o,
    .current_o, .smooth_o, .disabled_o, .position_o);
  sdc_pulse_gen gen (.clk_i, .step_o(step_pin), .dir_o(dir_pin), .dis_o(dis_pin));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_err(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected error flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Wait states come only from pready; the watchdog ends a hung transfer.
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========
  // Sequence
  initial begin
    reset_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    cyc(3);
    reset_i <= 1'b0;
    cyc(8);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].q);
      chk_err(e, rows[i].e);
    end
    for (int i = 0; i < 15; i++) begin
      apb(1'b1, sdc_pkg::ADDR_SUBDIV, 32'(i));
      cyc(2);
      chk(32'(subdivision_select_o), 32'(sub_exp[i]));
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, sdc_pkg::ADDR_CONTROL, 32'(i << 4));
      cyc(2);
      chk(32'(smooth_o), 32'(i));
    end
    $display("test registers done");
    reset_i <= 1'b1;
    cyc(3);
    reset_i <= 1'b0;
    chk(32'(subdivision_select_o), 32'h08);
    chk(32'(smooth_o), 32'h02);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    $display("test reset done");
    gen.pulses(5, 1'b0);
    chk(position_o, 32'h05);
    chk(32'(dir_cw_o), 32'h0);
    chk(32'(current_o), 32'h14);
    cyc(50);
    chk(32'(current_o), 32'h0a);
    gen.pulses(3, 1'b1);
    chk(position_o, 32'h02);
    chk(32'(dir_cw_o), 32'h1);
    apb(1'b1, sdc_pkg::ADDR_CONTROL, 32'h22);
    gen.pulses(2, 1'b0);
    chk(position_o, 32'h00);
    $display("test direction done");
    apb(1'b1, sdc_pkg::ADDR_CONTROL, 32'h21);
    gen.level(1'b1);
    chk(position_o, 32'h00);
    gen.level(1'b0);
    chk(position_o, 32'h01);
    apb(1'b1, sdc_pkg::ADDR_HOLD_DELAY, 32'h00);
    gen.pulses(1, 1'b0);
    cyc(2);
    chk(32'(current_o), 32'h0a);
    $display("test edge and delay done");
    gen.set_dis(1'b0);
    chk(32'(disabled_o), 32'h1);
    gen.pulses(1, 1'b0);
    chk(position_o, 32'h02);
    chk(32'(current_o), 32'h00);
    apb(1'b1, sdc_pkg::ADDR_CONTROL, 32'h24);
    cyc(8);
    chk(32'(disabled_o), 32'h0);
    gen.set_dis(1'b1);
    chk(32'(disabled_o), 32'h1);
    $display("test disable done");
    wrap_up();
  end
  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
